// [shared/slmc_defs.svh]
/*
  Constants for the scan line mask capture unit: register offsets, field
  positions, reset values and sizes. Assumes inclusion by bare name.
*/
`ifndef SLMC_DEFS_SVH
`define SLMC_DEFS_SVH
`define SLMC_MEM_WORDS 1024
`define SLMC_LINES 720
`define SLMC_LAST_LINE 10'h2CF
`define SLMC_ENTRY_PRESET 10'h3FF
`define SLMC_X_BITS 10
`define SLMC_WORD_BITS 12
`define SLMC_PROG_WORDS 8
`define SLMC_P2_MODE_LSB 8
`define SLMC_P7_DISP_LSB 10
// Host register offsets
`define SLMC_ADDR_CMD 4'h0
`define SLMC_ADDR_INDEX 4'h1
`define SLMC_ADDR_ENTRY 4'h2
`define SLMC_ADDR_EXIT 4'h3
`define SLMC_ADDR_STATUS 4'h4
`define SLMC_ADDR_PROG 4'h8
// Command register bits
`define SLMC_CMD_ARM 0
`define SLMC_CMD_START 1
// Status register bits
`define SLMC_STAT_DONE 0
`define SLMC_STAT_ARMED 1
`define SLMC_STAT_CAPT 2
`define SLMC_STAT_BUSY 3
`endif

// [shared/slmc_pkg.sv]
/*
  Types shared by both ends of the mask capture unit.
  Assumes slmc_defs.svh is on the include path.
*/
`default_nettype none
`include "slmc_defs.svh"
package slmc_pkg;
  typedef enum logic [2:0] {
    SLMC_OP_NONE = 3'h0,
    SLMC_OP_ARM = 3'h1,
    SLMC_OP_START = 3'h2,
    SLMC_OP_INDEX = 3'h3,
    SLMC_OP_RD_ENTRY = 3'h4,
    SLMC_OP_RD_EXIT = 3'h5,
    SLMC_OP_WR_ENTRY = 3'h6,
    SLMC_OP_WR_EXIT = 3'h7
  } slmc_op_e;
  typedef enum logic [1:0] {
    SLMC_IDLE = 2'b00,
    SLMC_ARMED = 2'b01,
    SLMC_WAIT = 2'b11,
    SLMC_CAPT = 2'b10
  } slmc_state_e;
  typedef logic [`SLMC_X_BITS-1:0] slmc_x_t;
  typedef logic [`SLMC_WORD_BITS-1:0] slmc_word_t;
endpackage
`default_nettype wire

// [shared/slmc_if.sv]
/*
  Instruction link between host controller and mask register unit.
  Assumes one common clock; an instruction is a one-cycle op pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
interface slmc_if;
  slmc_pkg::slmc_op_e op;
  slmc_pkg::slmc_word_t acc_out;
  slmc_pkg::slmc_word_t acc_in;
  logic acc_in_valid;
  logic done;
  logic [`SLMC_WORD_BITS*`SLMC_PROG_WORDS-1:0] prog;
  modport unit (input op, input acc_out, input prog, output acc_in, output acc_in_valid, output done);
  modport host (output op, output acc_out, output prog, input acc_in, input acc_in_valid, input done);
endinterface
`default_nettype wire

// [hdl/slmc_scan_addr.sv]
/*
  Scan address generator: line and pixel coordinates from scanner triggers.
  Assumes triggers are one-cycle pulses synchronous to clk; x counts on pixel_en.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
module slmc_scan_addr (
  input wire logic clk,
  input wire logic reset,
  input wire logic vertical_trigger,
  input wire logic horizontal_trigger,
  input wire logic pixel_en,
  output slmc_pkg::slmc_x_t x_reg,
  output slmc_pkg::slmc_x_t y_reg,
  output logic line_start_reg
);
  import slmc_pkg::*;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      x_reg <= '0;
    end else if (horizontal_trigger || vertical_trigger) begin
      x_reg <= '0;
    end else if (pixel_en && x_reg != `SLMC_ENTRY_PRESET) begin
      x_reg <= x_reg + 10'h001;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      y_reg <= '0;
    end else if (vertical_trigger) begin
      y_reg <= '0;
    end else if (horizontal_trigger && y_reg != `SLMC_ENTRY_PRESET) begin
      y_reg <= y_reg + 10'h001;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_start_reg <= 1'b0;
    end else begin
      line_start_reg <= horizontal_trigger || vertical_trigger;
    end
  end
endmodule // slmc_scan_addr
`default_nettype wire

// [hdl/slmc_unit.sv]
/*
  Mask register unit: captures first entry/exit X per line from detected
  video, replays the mask in step with the scan, serves host instructions.
  Assumes scanner triggers and video synchronous to clk (40 MHz).
*/
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
module slmc_unit #(
  parameter int DEPTH = `SLMC_MEM_WORDS,
  parameter int LINES = `SLMC_LINES
) (
  input wire logic clk,
  input wire logic reset,
  slmc_if.unit link,
  input wire logic vertical_trigger,
  input wire logic horizontal_trigger,
  input wire logic pixel_en,
  input wire logic live_frame,
  input wire logic detected_video,
  input wire logic frame_window,
  output logic detect_gate_reg,
  output logic mask_display_reg
);
  import slmc_pkg::*;
  initial begin
    if (DEPTH < LINES || DEPTH > `SLMC_MEM_WORDS || LINES < 1) begin
      $error("slmc_unit: unsupported DEPTH or LINES");
    end
  end

  slmc_x_t entry_mem [DEPTH];
  slmc_x_t exit_mem [DEPTH];
  slmc_x_t x_now;
  slmc_x_t y_now;
  logic line_start;
  slmc_state_e state_reg;
  slmc_x_t index_reg;
  logic inside_reg;
  logic seen_reg;
  logic ended_reg;
  logic prev_vertical_trigger_reg;
  logic capturing;
  logic line_ok;
  logic index_ok;
  logic [3:0] mode;
  logic [1:0] disp_sel;
  logic in_mask;

  slmc_scan_addr u_addr (
    .clk(clk),
    .reset(reset),
    .vertical_trigger(vertical_trigger),
    .horizontal_trigger(horizontal_trigger),
    .pixel_en(pixel_en),
    .x_reg(x_now),
    .y_reg(y_now),
    .line_start_reg(line_start)
  );

  function automatic logic in_range(input slmc_x_t v);
    in_range = v <= `SLMC_LAST_LINE;
  endfunction

  assign capturing = state_reg == SLMC_CAPT;
  assign line_ok = in_range(y_now) && live_frame;
  assign index_ok = in_range(index_reg);
  // Program word two is the second word on the bus
  assign mode = link.prog[`SLMC_WORD_BITS+`SLMC_P2_MODE_LSB+:4];
  assign disp_sel = link.prog[`SLMC_WORD_BITS*6+`SLMC_P7_DISP_LSB+:2];
  // Same x/y counters as the frame window, so stored X aligns with it
  assign in_mask = (x_now >= entry_mem[y_now]) && (x_now < exit_mem[y_now]);

  // Capture sequencing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= SLMC_IDLE;
    end else begin
      unique case (state_reg)
        SLMC_IDLE: if (link.op == SLMC_OP_ARM) state_reg <= SLMC_ARMED;
        SLMC_ARMED: if (link.op == SLMC_OP_START) state_reg <= SLMC_WAIT;
        SLMC_WAIT: if (vertical_trigger) state_reg <= SLMC_CAPT;
        SLMC_CAPT: if (vertical_trigger) state_reg <= SLMC_IDLE;
      endcase
    end
  end

  // Frame end seen as the next vertical trigger after the captured frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_vertical_trigger_reg <= 1'b0;
    end else begin
      prev_vertical_trigger_reg <= vertical_trigger;
    end
  end

  // Plain scans without arming also report done at their frame end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ended_reg <= 1'b0;
    end else if (state_reg == SLMC_IDLE && prev_vertical_trigger_reg) begin
      ended_reg <= 1'b1;
    end else if (link.op == SLMC_OP_START) begin
      ended_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.done <= 1'b1;
    end else if (capturing && vertical_trigger) begin
      link.done <= 1'b1;
    end else if (link.op == SLMC_OP_START) begin
      link.done <= 1'b0;
    end else if (state_reg == SLMC_IDLE && ended_reg) begin
      link.done <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      index_reg <= '0;
    end else if (link.op == SLMC_OP_INDEX) begin
      index_reg <= link.acc_out[`SLMC_X_BITS-1:0];
    end
  end

  // Per-line entry/exit tracking; only the first object counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inside_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (line_start || !capturing) begin
      inside_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (line_ok && pixel_en) begin
      if (!seen_reg && detected_video) begin
        inside_reg <= 1'b1;
        seen_reg <= 1'b1;
      end else if (inside_reg && !detected_video) begin
        inside_reg <= 1'b0;
      end
    end
  end

  // Memory writes: capture has the RAM; host writes only outside capture
  always_ff @(posedge clk) begin
    if (capturing) begin
      if (line_start && in_range(y_now)) begin
        entry_mem[y_now] <= `SLMC_ENTRY_PRESET;
        exit_mem[y_now] <= `SLMC_ENTRY_PRESET;
      end else if (line_ok && pixel_en) begin
        if (!seen_reg && detected_video) begin
          entry_mem[y_now] <= x_now;
        end else if (inside_reg && !detected_video) begin
          exit_mem[y_now] <= x_now;
        end
      end
    end else if (index_ok) begin
      if (link.op == SLMC_OP_WR_ENTRY) begin
        entry_mem[index_reg] <= link.acc_out[`SLMC_X_BITS-1:0];
      end
      if (link.op == SLMC_OP_WR_EXIT) begin
        exit_mem[index_reg] <= link.acc_out[`SLMC_X_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.acc_in <= '0;
      link.acc_in_valid <= 1'b0;
    end else begin
      link.acc_in_valid <= link.op == SLMC_OP_RD_ENTRY || link.op == SLMC_OP_RD_EXIT;
      if (link.op == SLMC_OP_RD_ENTRY) begin
        link.acc_in <= index_ok ? {2'b00, entry_mem[index_reg]} : '0;
      end else if (link.op == SLMC_OP_RD_EXIT) begin
        link.acc_in <= index_ok ? {2'b00, exit_mem[index_reg]} : '0;
      end
    end
  end

  // Replay: mode 0 frame, 1 mask, 2 and, 3 or, 4 frame and not mask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      detect_gate_reg <= 1'b0;
    end else if (capturing) begin
      detect_gate_reg <= frame_window;
    end else begin
      unique case (mode)
        4'h0: detect_gate_reg <= frame_window;
        4'h1: detect_gate_reg <= in_mask;
        4'h2: detect_gate_reg <= frame_window && in_mask;
        4'h3: detect_gate_reg <= frame_window || in_mask;
        4'h4: detect_gate_reg <= frame_window && !in_mask;
        default: detect_gate_reg <= frame_window;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_display_reg <= 1'b0;
    end else begin
      mask_display_reg <= (disp_sel != 2'b00) && !capturing && in_mask;
    end
  end
endmodule // slmc_unit
`default_nettype wire

// [hdl/slmc_host.sv]
/*
  Host end: turns software register accesses into one-cycle instructions
  and holds the eight program words. Assumes plain port bus, read data next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
module slmc_host (
  input wire logic clk,
  input wire logic reset,
  slmc_if.host link,
  input wire logic [3:0] addr,
  input wire logic [11:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [11:0] rdata_reg
);
  import slmc_pkg::*;
  slmc_word_t prog_reg [`SLMC_PROG_WORDS];
  slmc_word_t last_reg;
  logic busy_reg;
  logic armed_reg;

  // One process drives the whole program bus, so it has a single driver
  always_comb begin
    for (int i = 0; i < `SLMC_PROG_WORDS; i++) begin
      link.prog[i*`SLMC_WORD_BITS+:`SLMC_WORD_BITS] = prog_reg[i];
    end
  end

  // Program words loaded before each scan
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `SLMC_PROG_WORDS; i++) prog_reg[i] <= '0;
    end else if (wr && addr[3]) begin
      prog_reg[addr[2:0]] <= wdata;
    end
  end

  // Entry/exit transfers refused while a scan is busy; command and index writes still pass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.op <= SLMC_OP_NONE;
      link.acc_out <= '0;
    end else begin
      link.op <= SLMC_OP_NONE;
      link.acc_out <= wdata;
      if (wr && addr == `SLMC_ADDR_CMD && wdata[`SLMC_CMD_ARM]) begin
        link.op <= SLMC_OP_ARM;
      end else if (wr && addr == `SLMC_ADDR_CMD && wdata[`SLMC_CMD_START]) begin
        link.op <= SLMC_OP_START;
      end else if (wr && addr == `SLMC_ADDR_INDEX) begin
        link.op <= SLMC_OP_INDEX;
      end else if (!busy_reg && wr && addr == `SLMC_ADDR_ENTRY) begin
        link.op <= SLMC_OP_WR_ENTRY;
      end else if (!busy_reg && wr && addr == `SLMC_ADDR_EXIT) begin
        link.op <= SLMC_OP_WR_EXIT;
      end else if (!busy_reg && rd && addr == `SLMC_ADDR_ENTRY) begin
        link.op <= SLMC_OP_RD_ENTRY;
      end else if (!busy_reg && rd && addr == `SLMC_ADDR_EXIT) begin
        link.op <= SLMC_OP_RD_EXIT;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (wr && addr == `SLMC_ADDR_CMD && wdata[`SLMC_CMD_ARM]) begin
      armed_reg <= 1'b1;
    end else if (wr && addr == `SLMC_ADDR_CMD && wdata[`SLMC_CMD_START]) begin
      busy_reg <= 1'b1;
    end else if (busy_reg && link.done && link.op != SLMC_OP_START) begin
      busy_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_reg <= '0;
    end else if (link.acc_in_valid) begin
      last_reg <= link.acc_in;
    end
  end

  // Read of entry/exit returns the word fetched by the previous read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (rd) begin
      unique case (addr)
        `SLMC_ADDR_STATUS: rdata_reg <= {8'h00, busy_reg, 1'b0, armed_reg, link.done && !busy_reg};
        `SLMC_ADDR_ENTRY, `SLMC_ADDR_EXIT: rdata_reg <= last_reg;
        default: rdata_reg <= addr[3] ? prog_reg[addr[2:0]] : 12'h000;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
endmodule // slmc_host
`default_nettype wire

// [verif/slmc_checker.sv]
/*
  Checker for the instruction link between host end and mask unit.
  Assumes one clock, asynchronous active-high reset, link signals as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
module slmc_checker (
  input wire logic clk,
  input wire logic reset,
  input wire slmc_pkg::slmc_op_e op,
  input wire slmc_pkg::slmc_word_t acc_out,
  input wire slmc_pkg::slmc_word_t acc_in,
  input wire logic acc_in_valid,
  input wire logic done
);
  import slmc_pkg::*;
  logic oob_reg, ent_ok_reg, ext_ok_reg;
  slmc_x_t ent_reg, ext_reg;
  wire logic rd_op = (op == SLMC_OP_RD_ENTRY) || (op == SLMC_OP_RD_EXIT);
  // Shadow of the last host write to the indexed line; a capture makes it stale
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oob_reg <= 1'b0;
      ent_ok_reg <= 1'b0;
      ext_ok_reg <= 1'b0;
      ent_reg <= '0;
      ext_reg <= '0;
    end else if (!done || op == SLMC_OP_INDEX) begin
      oob_reg <= (op == SLMC_OP_INDEX) ? (acc_out > {2'h0, `SLMC_LAST_LINE}) : oob_reg;
      ent_ok_reg <= 1'b0;
      ext_ok_reg <= 1'b0;
    end else if (op == SLMC_OP_WR_ENTRY && !oob_reg) begin
      ent_reg <= acc_out[9:0];
      ent_ok_reg <= 1'b1;
    end else if (op == SLMC_OP_WR_EXIT && !oob_reg) begin
      ext_reg <= acc_out[9:0];
      ext_ok_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_done_clear_start: assert property (op == SLMC_OP_START |=> !done) else $error("done not cleared");
  a_done_fall_cause: assert property ($fell(done) |-> $past(op) == SLMC_OP_START) else $error("done fell");
  a_read_answer: assert property (rd_op && done |=> acc_in_valid) else $error("read unanswered");
  a_valid_cause: assert property (acc_in_valid |-> $past(rd_op)) else $error("stray valid");
  a_read_ten_bits: assert property (acc_in_valid |-> acc_in[11:10] == 2'h0) else $error("wide value");
  a_oob_read_zero: assert property (rd_op && done && oob_reg |=> acc_in == 12'h000) else $error("oob read");
  a_entry_readback: assert property (op == SLMC_OP_RD_ENTRY && ent_ok_reg |=> acc_in == {2'h0, ent_reg})
    else $error("entry readback");
  a_exit_readback: assert property (op == SLMC_OP_RD_EXIT && ext_ok_reg |=> acc_in == {2'h0, ext_reg})
    else $error("exit readback");
  a_acc_holds: assert property (!acc_in_valid |-> $stable(acc_in)) else $error("acc_in moved");
  c_capture_done: cover property ($rose(done));
  c_oob_read: cover property (rd_op && done && oob_reg);
  c_exit_back: cover property (op == SLMC_OP_RD_EXIT && ext_ok_reg);
endmodule // slmc_checker
`default_nettype wire

// [verif/scan_line_mask_capture_tb.sv]
/*
  Testbench: host end and mask unit joined by the link, driven through the
  software port and scanner inputs. Assumes x counts pixel strobes from 0 per line.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slmc_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module scan_line_mask_capture_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic vertical_trigger = 1'b0, horizontal_trigger = 1'b0, pixel_en = 1'b0, detected_video = 1'b0;
  logic live_frame = 1'b1, frame_window = 1'b1, wr = 1'b0, rd = 1'b0, cnt_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [11:0] wdata = 12'h000, rdata_reg, got;
  logic detect_gate_reg, mask_display_reg;
  int fail_count = 0, tests_run = 0, cycles = 0, gate_cnt, disp_cnt, span_cnt, e;
  // Line 1 holds a second object that must be ignored; line 2 never leaves
  logic [39:0] pat [3] = '{40'h0, 40'h0003F003E0, 40'hFFC0000000};
  slmc_if lk ();
  slmc_unit #(.DEPTH(`SLMC_MEM_WORDS), .LINES(`SLMC_LINES)) slmc_unit_i (.clk(clk), .reset(reset), .link(lk),
    .vertical_trigger(vertical_trigger), .horizontal_trigger(horizontal_trigger), .pixel_en(pixel_en),
    .live_frame(live_frame), .detected_video(detected_video), .frame_window(frame_window),
    .detect_gate_reg(detect_gate_reg), .mask_display_reg(mask_display_reg));
  slmc_host slmc_host_i (.clk(clk), .reset(reset), .link(lk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_reg(rdata_reg));
  slmc_checker slmc_checker_i (.clk(clk), .reset(reset), .op(lk.op), .acc_out(lk.acc_out), .acc_in(lk.acc_in),
    .acc_in_valid(lk.acc_in_valid), .done(lk.done));
  always #12.5 clk = ~clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cnt_en) begin
      span_cnt++;
      gate_cnt += int'(detect_gate_reg === 1'b1);
      disp_cnt += int'(mask_display_reg === 1'b1);
    end
    if (cycles == 20000) begin
      fail_count++;
      $display("timeout");
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [11:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_reg;
  endtask
  // The port answers with the previous fetch, so every mask read is issued twice
  task automatic mask_rd(input logic [3:0] a, output logic [11:0] d);
    bus_rd(a, d);
    tick(4);
    bus_rd(a, d);
  endtask
  task automatic chk_line(input logic [11:0] y, input logic [11:0] en, input logic [11:0] ex);
    bus_wr(`SLMC_ADDR_INDEX, y);
    mask_rd(`SLMC_ADDR_ENTRY, got);
    `CHK("entry", en, got)
    mask_rd(`SLMC_ADDR_EXIT, got);
    `CHK("exit", ex, got)
  endtask
  task automatic vpulse();
    @(posedge clk);
    vertical_trigger <= 1'b1;
    @(posedge clk);
    vertical_trigger <= 1'b0;
  endtask
  task automatic scan_line(input logic [39:0] p, input logic c);
    @(posedge clk);
    horizontal_trigger <= 1'b1;
    cnt_en <= c;
    @(posedge clk);
    horizontal_trigger <= 1'b0;
    tick(2);
    for (int x = 0; x < 40; x++) begin
      detected_video <= p[x];
      pixel_en <= 1'b1;
      @(posedge clk);
      pixel_en <= 1'b0;
      @(posedge clk);
    end
    detected_video <= 1'b0;
    tick(4);
    cnt_en <= 1'b0;
  endtask
  task automatic frame(input logic c);
    gate_cnt = 0;
    disp_cnt = 0;
    span_cnt = 0;
    vpulse();
    for (int y = 0; y < 3; y++) scan_line(pat[y], c && y == 1);
    tick(20);
  endtask
  initial begin
    tick(6);
    reset <= 1'b0;
    tick(2);
    bus_rd(`SLMC_ADDR_STATUS, got);
    `CHK("status", 12'h001, got)
    bus_wr(`SLMC_ADDR_INDEX, 12'h2CF);
    bus_wr(`SLMC_ADDR_ENTRY, 12'h155);
    bus_wr(`SLMC_ADDR_EXIT, 12'h2AA);
    chk_line(12'h2CF, 12'h155, 12'h2AA);
    bus_wr(`SLMC_ADDR_INDEX, 12'h2D0);
    bus_wr(`SLMC_ADDR_ENTRY, 12'h011);
    mask_rd(`SLMC_ADDR_ENTRY, got);
    `CHK("oob entry", 12'h000, got)
    $display("test host_io done");
    bus_wr(`SLMC_ADDR_CMD, 12'h001);
    bus_wr(`SLMC_ADDR_CMD, 12'h002);
    tick(2);
    bus_rd(`SLMC_ADDR_STATUS, got);
    `CHK("done cleared", 1'b0, got[0])
    // A line before the frame top must not start the acquisition
    scan_line(pat[1], 1'b0);
    frame(1'b0);
    bus_rd(`SLMC_ADDR_STATUS, got);
    `CHK("done mid capture", 1'b0, got[0])
    vpulse();
    for (int i = 0; i < 50 && got[0] !== 1'b1; i++) bus_rd(`SLMC_ADDR_STATUS, got);
    `CHK("done set", 1'b1, got[0])
    // Each line trigger advances y first, so the bench's lines land on 1 to 3
    chk_line(12'h001, 12'h3FF, 12'h3FF);
    chk_line(12'h002, 12'h005, 12'h00A);
    chk_line(12'h003, 12'h01E, 12'h3FF);
    $display("test capture done");
    bus_wr(`SLMC_ADDR_PROG + 4'h6, 12'hC00);
    for (int m = 0; m < 5; m++) begin
      bus_wr(`SLMC_ADDR_PROG + 4'h1, {m[3:0], 8'h00});
      frame(1'b1);
      e = (m == 1 || m == 2) ? 10 : (m == 4 ? span_cnt - 10 : span_cnt);
      `CHK("gate cycles", e, gate_cnt)
      `CHK("display cycles", 10, disp_cnt)
    end
    bus_wr(`SLMC_ADDR_PROG + 4'h6, 12'h000);
    frame(1'b1);
    `CHK("display off", 0, disp_cnt)
    $display("test replay done");
    end_of_test();
  end
endmodule // scan_line_mask_capture_tb
`default_nettype wire
